// *** inc/tpfs_map.svh ***
`ifndef TPFS_MAP_SVH
`define TPFS_MAP_SVH
`define TPFS_CTRL_OFS  12'h000
`define TPFS_STAT_OFS  12'h004
`define TPFS_CTRL_RST  32'h0000_0001
`define TPFS_CTRL_MSK  32'h0000_3FFF
`define TPFS_C_DRST    0
`define TPFS_C_BOND    1
`define TPFS_C_X8      2
`define TPFS_C_MAST    3
`define TPFS_C_DIV     4
`define TPFS_C_BS      6
`define TPFS_C_DBL     7
`define TPFS_C_W10     8
`define TPFS_C_ENC     9
`define TPFS_C_BYP     10
`define TPFS_C_PRO     11
`define TPFS_C_FCLK    13
`define TPFS_S_STKY    0
`define TPFS_DEP_LO    4'h4
`define TPFS_DEP_HI    4'h8
`define TPFS_DEP_REG   4'h2
`define TPFS_PRE_LO    4'h2
`define TPFS_PRE_HI    4'h4
`define TPFS_PRE_REG   4'h1
`define TPFS_DIV1      2'h0
`define TPFS_DIV2      2'h1
`define TPFS_DIV4      2'h2
`endif

// *** inc/tpfs_pkg.sv ***
package tpfs_pkg;
  typedef enum logic [1:0] {
    TPFS_FM_LOW  = 2'b00,
    TPFS_FM_HIGH = 2'b01,
    TPFS_FM_REG  = 2'b10
  } tpfs_fmode_t;
  typedef enum logic [1:0] {
    TPFS_PR_BASIC  = 2'b00,
    TPFS_PR_PCIE   = 2'b01,
    TPFS_PR_DETLAT = 2'b10,
    TPFS_PR_OTHER  = 2'b11
  } tpfs_proto_t;
endpackage : tpfs_pkg

// *** rtl/tpfs_mem.sv ***
`timescale 1ns/1ps
module tpfs_mem (
  input  wire logic        clk_i,    // system clock
  input  wire logic        arst_n_i, // async reset, low
  input  wire logic        we_i,     // write strobe
  input  wire logic [2:0]  waddr_i,  // write slot
  input  wire logic [39:0] wdata_i,  // write word
  input  wire logic        re_i,     // read strobe
  input  wire logic [2:0]  raddr_i,  // read slot
  output logic      [39:0] rdata_o   // registered read word
);
  logic [39:0] mem_q [8];
  logic [39:0] rdata_d;

  always_comb begin
    rdata_d = re_i ? mem_q[raddr_i] : rdata_o;
  end

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 40'h00_0000_0000;
    end else begin
      rdata_o <= rdata_d;
    end
  end
endmodule : tpfs_mem

// *** rtl/tpfs_div.sv ***
`timescale 1ns/1ps
`include "tpfs_map.svh"
module tpfs_div
  import tpfs_pkg::*;
(
  input  wire logic       clk_i,    // system clock
  input  wire logic       arst_n_i, // async reset, low
  input  wire logic [1:0] ratio_i,  // 0 /1, 1 /2, 2 /4
  output logic            en_o      // one-cycle rate pulse
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] lim;
  logic       en_d;

  always_comb begin
    // the unused fourth code also divides by four
    if (ratio_i >= `TPFS_DIV4) begin
      lim = 2'h3;
    end else if (ratio_i == `TPFS_DIV2) begin
      lim = 2'h1;
    end else begin
      lim = 2'h0;
    end
    cnt_d = (cnt_q == 2'h0 || cnt_q > lim) ? lim : cnt_q - 2'h1;
    en_d  = (cnt_q == 2'h0);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 2'h0;
      en_o  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      en_o  <= en_d;
    end
  end
endmodule : tpfs_div

// *** rtl/tpfs_top.sv ***
// Functional notes
// - local divider gives PLL rate /1 /2 /4
// - PLL feeds bonded or local divider
// - bonded core clock halves with byte serializer
// - x8 uses master block's shared divider only
// - single width 8/10, fabric doubles with serializer
// - double width 16/20, serializer per variant
// - double width only basic or deterministic latency
// - low latency FIFO four deep, 2-3 cycles
// - high latency PCIe FIFO eight deep, 4-5
// - error flag on overflow or underflow
// - write clock fabric clock else read clock
// - read clock local or bonded core clock
// - FIFO output routes serializer, encoder or serializer
// - byte serializer halves width, doubles rate
// - low half sent first
// - serializer output to encoder if 16-bit
// - digital reset clears FIFO and serializer
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tpfs_map.svh"
module tpfs_top
  import tpfs_pkg::*;
#(
  parameter logic ALLOW_BS_DW = 1'b0 // variant allowing serializer in double width
) (
  input  wire logic        SYS_CLK_I,    // 100 MHz clock, the PLL rate
  input  wire logic        ARST_N_I,     // async reset, low
  input  wire logic        PSEL_I,       // apb select
  input  wire logic        PENABLE_I,    // apb enable
  input  wire logic        PWRITE_I,     // apb direction
  input  wire logic [11:0] PADDR_I,      // apb byte address
  input  wire logic [31:0] PWDATA_I,     // apb write data
  output logic      [31:0] PRDATA_O,     // apb read data
  output logic             PREADY_O,     // apb ready
  output logic             PSLVERR_O,    // apb error, unmapped
  input  wire logic [39:0] FAB_DATA_I,   // fabric word
  input  wire logic        FAB_CLK_EN_I, // fabric core clock enable
  input  wire logic        BOND_EN_I,    // shared divider enable from master
  output logic             BOND_EN_O,    // shared enable to x8 slaves
  output logic             CORE_EN_O,    // core clock enable to fabric
  output logic             PAR_EN_O,     // parallel clock enable
  output logic      [19:0] OUT_DATA_O,   // word to encoder or serializer
  output logic             OUT_VALID_O,  // word valid pulse
  output logic             OUT_TO_ENC_O, // 1 encoder, 0 serializer
  output logic             FIFO_ERR_O    // overflow or underflow pulse
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  logic [31:0] ctrl_q, ctrl_d, prdata_d;
  logic        stky_q, stky_d, pready_d, pslverr_d;
  logic        lcl_en, bnd_en, par_en, core_en;
  logic        drst, bonded, x8, master, bs_eff, dw_eff, wide, fclk;
  logic [1:0]  ldiv, iw;
  tpfs_proto_t proto;
  tpfs_fmode_t fmode;
  logic [3:0]  dep, pre;
  logic [2:0]  msk;
  logic [2:0]  wp_q, wp_d, rp_q, rp_d;
  logic [3:0]  cnt_q, cnt_d, pad_q, pad_d;
  logic        wr, rd, wr_ok, rd_ok, ovf, udf;
  logic [39:0] rdata;
  logic        phase_q, phase_d, rvld_q, rvld_d, hvld_q, hvld_d;
  logic [19:0] hi_q, hi_d, lo_c, hi_c, out_d;
  logic        ovld_d, rte_d;

  function automatic logic [19:0] tpfs_cut(input logic [39:0] d, input logic [1:0] w, input logic hi);
    logic [19:0] r;
    case (w)
      2'h0: r = hi ? {12'h000, d[15:8]} : {12'h000, d[7:0]};
      2'h1: r = hi ? {10'h000, d[19:10]} : {10'h000, d[9:0]};
      2'h2: r = hi ? {4'h0, d[31:16]} : {4'h0, d[15:0]};
      default: r = hi ? d[39:20] : d[19:0];
    endcase
    return r;
  endfunction : tpfs_cut

  assign drst   = ctrl_q[`TPFS_C_DRST];
  assign bonded = ctrl_q[`TPFS_C_BOND];
  assign x8     = ctrl_q[`TPFS_C_X8];
  assign master = ctrl_q[`TPFS_C_MAST];
  assign ldiv   = ctrl_q[`TPFS_C_DIV +: 2];
  assign wide   = ctrl_q[`TPFS_C_W10];
  assign fclk   = ctrl_q[`TPFS_C_FCLK];
  assign proto  = tpfs_proto_t'(ctrl_q[`TPFS_C_PRO +: 2]);

  // divider settings above the three legal ratios behave as /4
  tpfs_div u_lcl_div (
    .clk_i    (SYS_CLK_I),
    .arst_n_i (ARST_N_I),
    .ratio_i  (ldiv),
    .en_o     (lcl_en)
  );

  tpfs_div u_bnd_div (
    .clk_i    (SYS_CLK_I),
    .arst_n_i (ARST_N_I),
    .ratio_i  (ldiv),
    .en_o     (bnd_en)
  );

  tpfs_mem u_mem (
    .clk_i    (SYS_CLK_I),
    .arst_n_i (ARST_N_I),
    .we_i     (wr_ok),
    .waddr_i  (wp_q),
    .wdata_i  (FAB_DATA_I),
    .re_i     (rd_ok),
    .raddr_i  (rp_q),
    .rdata_o  (rdata)
  );

  always_comb begin
    // x8 slaves ignore their own divider to keep lane skew low
    if (!bonded) begin
      par_en = lcl_en;
    end else if (x8 && !master) begin
      par_en = BOND_EN_I;
    end else begin
      par_en = bnd_en;
    end
    dw_eff = ctrl_q[`TPFS_C_DBL] && (proto == TPFS_PR_BASIC || proto == TPFS_PR_DETLAT);
    bs_eff = ctrl_q[`TPFS_C_BS] && (!dw_eff || ALLOW_BS_DW);
    iw     = {dw_eff, wide};
    core_en = par_en && (!bs_eff || !phase_q);
    case (proto)
      TPFS_PR_PCIE: fmode = TPFS_FM_HIGH;
      TPFS_PR_DETLAT: fmode = TPFS_FM_REG;
      default: fmode = TPFS_FM_LOW;
    endcase
    case (fmode)
      TPFS_FM_HIGH: begin
        dep = `TPFS_DEP_HI;
        pre = `TPFS_PRE_HI;
      end
      TPFS_FM_REG: begin
        dep = `TPFS_DEP_REG;
        pre = `TPFS_PRE_REG;
      end
      default: begin
        dep = `TPFS_DEP_LO;
        pre = `TPFS_PRE_LO;
      end
    endcase
    msk = dep[2:0] - 3'h1;
  end

  // fifo pointers; preloaded slots read out as invalid
  always_comb begin
    wr    = !drst && (fclk ? FAB_CLK_EN_I : core_en);
    rd    = !drst && core_en;
    rd_ok = rd && (cnt_q != 4'h0);
    wr_ok = wr && (cnt_q < dep || rd_ok);
    ovf   = wr && !wr_ok;
    udf   = rd && !rd_ok;
    wp_d  = wr_ok ? ((wp_q + 3'h1) & msk) : wp_q;
    rp_d  = rd_ok ? ((rp_q + 3'h1) & msk) : rp_q;
    cnt_d = cnt_q + {3'h0, wr_ok} - {3'h0, rd_ok};
    pad_d = (rd_ok && pad_q != 4'h0) ? pad_q - 4'h1 : pad_q;
    if (drst) begin
      wp_d  = pre[2:0];
      rp_d  = 3'h0;
      cnt_d = pre;
      pad_d = pre;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wp_q  <= 3'h0;
      rp_q  <= 3'h0;
      cnt_q <= 4'h0;
      pad_q <= 4'h0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      pad_q <= pad_d;
    end
  end

  // byte serializer and output routing
  always_comb begin
    lo_c    = tpfs_cut(rdata, iw, 1'b0);
    hi_c    = tpfs_cut(rdata, iw, 1'b1);
    phase_d = phase_q;
    rvld_d  = rvld_q;
    hvld_d  = hvld_q;
    hi_d    = hi_q;
    out_d   = OUT_DATA_O;
    ovld_d  = 1'b0;
    if (core_en) begin
      rvld_d = rd_ok && pad_q == 4'h0;
    end
    if (par_en && bs_eff) begin
      phase_d = !phase_q;
      if (phase_q) begin
        out_d  = rvld_q ? lo_c : 20'h00000;
        ovld_d = rvld_q;
        hi_d   = hi_c;
        hvld_d = rvld_q;
      end else begin
        out_d  = hvld_q ? hi_q : 20'h00000;
        ovld_d = hvld_q;
        hvld_d = 1'b0;
      end
    end else if (par_en) begin
      out_d  = rvld_q ? lo_c : 20'h00000;
      ovld_d = rvld_q;
    end
    if (bs_eff) begin
      rte_d = ctrl_q[`TPFS_C_ENC] && !wide && !dw_eff;
    end else begin
      rte_d = ctrl_q[`TPFS_C_ENC] && !wide && !ctrl_q[`TPFS_C_BYP];
    end
    if (drst || !bs_eff) begin
      phase_d = 1'b0;
      hvld_d  = 1'b0;
    end
    if (drst) begin
      rvld_d = 1'b0;
      out_d  = 20'h00000;
      ovld_d = 1'b0;
      hi_d   = 20'h00000;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase_q      <= 1'b0;
      rvld_q       <= 1'b0;
      hvld_q       <= 1'b0;
      hi_q         <= 20'h00000;
      OUT_DATA_O   <= 20'h00000;
      OUT_VALID_O  <= 1'b0;
      OUT_TO_ENC_O <= 1'b0;
      FIFO_ERR_O   <= 1'b0;
      CORE_EN_O    <= 1'b0;
      BOND_EN_O    <= 1'b0;
      PAR_EN_O     <= 1'b0;
    end else begin
      phase_q      <= phase_d;
      rvld_q       <= rvld_d;
      hvld_q       <= hvld_d;
      hi_q         <= hi_d;
      OUT_DATA_O   <= out_d;
      OUT_VALID_O  <= ovld_d;
      OUT_TO_ENC_O <= rte_d;
      FIFO_ERR_O   <= ovf || udf;
      CORE_EN_O    <= core_en;
      BOND_EN_O    <= bnd_en;
      PAR_EN_O     <= par_en;
    end
  end

  // apb slave: one wait state so read data leaves a flop
  always_comb begin
    ctrl_d    = ctrl_q;
    stky_d    = stky_q || ovf || udf;
    pready_d  = PSEL_I && PENABLE_I && !PREADY_O;
    prdata_d  = PRDATA_O;
    pslverr_d = 1'b0;
    if (pready_d) begin
      if (PADDR_I == `TPFS_CTRL_OFS) begin
        prdata_d = ctrl_q;
      end else if (PADDR_I == `TPFS_STAT_OFS) begin
        prdata_d = {20'h00000, drst, OUT_TO_ENC_O, dw_eff, bs_eff, fmode, cnt_q, FIFO_ERR_O, stky_q};
      end else begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b1;
      end
    end
    if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I) begin
      if (PADDR_I == `TPFS_CTRL_OFS) begin
        ctrl_d = PWDATA_I & `TPFS_CTRL_MSK;
      end else if (PADDR_I == `TPFS_STAT_OFS) begin
        // a new error in the clearing cycle keeps the flag
        stky_d = (stky_q && !PWDATA_I[`TPFS_S_STKY]) || ovf || udf;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_q    <= `TPFS_CTRL_RST;
      stky_q    <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      stky_q    <= stky_d;
      PRDATA_O  <= prdata_d;
      PREADY_O  <= pready_d;
      PSLVERR_O <= pslverr_d;
    end
  end

  sequence s_div4_pulse;
    lcl_en && ldiv == `TPFS_DIV4 && $stable(ldiv);
  endsequence
  // a ratio change keeps the running count (reloaded only if above the new limit), so the check stands down then
  property p_div4;
    disable iff (!ARST_N_I || ldiv != `TPFS_DIV4)
    s_div4_pulse |=> !lcl_en [*3] ##1 lcl_en;
  endproperty
  a_div4: assert property (p_div4) else $error("local divide by four wrong");

  property p_src;
    !bonded && !lcl_en |-> !par_en;
  endproperty
  a_src: assert property (p_src) else $error("non-bonded rate not from local divider");

  property p_core;
    bonded && bs_eff && !drst && core_en && $stable(ctrl_q) |=> !core_en;
  endproperty
  a_core: assert property (p_core) else $error("core clock not halved");

  property p_x8;
    bonded && x8 && !master |-> par_en == BOND_EN_I;
  endproperty
  a_x8: assert property (p_x8) else $error("x8 slave not on master divider");

  property p_bsdw;
    dw_eff && !ALLOW_BS_DW |-> !bs_eff;
  endproperty
  a_bsdw: assert property (p_bsdw) else $error("serializer in double width");

  property p_dwpro;
    dw_eff |-> proto == TPFS_PR_BASIC || proto == TPFS_PR_DETLAT;
  endproperty
  a_dwpro: assert property (p_dwpro) else $error("double width in wrong protocol");

  property p_dlo;
    fmode == TPFS_FM_LOW |-> cnt_q <= `TPFS_DEP_LO;
  endproperty
  a_dlo: assert property (p_dlo) else $error("low latency depth exceeded");

  property p_dhi;
    fmode == TPFS_FM_HIGH |-> cnt_q <= `TPFS_DEP_HI;
  endproperty
  a_dhi: assert property (p_dhi) else $error("high latency depth exceeded");

  property p_err;
    ovf || udf |=> FIFO_ERR_O;
  endproperty
  a_err: assert property (p_err) else $error("fifo error not flagged");

  property p_wclk;
    !fclk && wr_ok |-> core_en;
  endproperty
  a_wclk: assert property (p_wclk) else $error("write off read clock");

  sequence s_lo_take;
    par_en && bs_eff && phase_q && rvld_q && !drst;
  endsequence
  property p_lofirst;
    s_lo_take |=> OUT_VALID_O && OUT_DATA_O == $past(lo_c);
  endproperty
  a_lofirst: assert property (p_lofirst) else $error("low half not first");

  property p_byp;
    ctrl_q[`TPFS_C_BYP] && !bs_eff |=> !OUT_TO_ENC_O;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass routed to encoder");

  property p_bsrte;
    bs_eff && wide |=> !OUT_TO_ENC_O;
  endproperty
  a_bsrte: assert property (p_bsrte) else $error("20-bit split routed to encoder");

  property p_drst;
    drst |=> !OUT_VALID_O ##0 !rvld_q;
  endproperty
  a_drst: assert property (p_drst) else $error("output live in digital reset");

  property p_pre;
    $fell(drst) |-> cnt_q == pre && rp_q == 3'h0;
  endproperty
  a_pre: assert property (p_pre) else $error("pointer gap wrong at release");
endmodule : tpfs_top

// *** test/tpfs_fab_model.sv ***
`timescale 1ns/1ps
module tpfs_fab_model (
  input  wire logic        clk_i,       // system clock
  input  wire logic        arst_n_i,    // async reset, low
  input  wire logic [1:0]  mode_i,      // 0 stall, 1 zero ppm, 2 overrun
  input  wire logic [39:0] word_i,      // word to present
  input  wire logic        core_en_i,   // core clock enable from block
  output logic      [39:0] fab_data_o,  // fabric word
  output logic             fab_clk_en_o // fabric write clock enable
);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fab_data_o   <= '0;
      fab_clk_en_o <= 1'b0;
    end else begin
      fab_data_o   <= word_i;
      // one write per core slot; fixed lag keeps zero ppm
      fab_clk_en_o <= (mode_i == 2'h1) ? core_en_i : (mode_i == 2'h2);
    end
  end
endmodule : tpfs_fab_model

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "tpfs_map.svh"
module tb;
  import tpfs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, fclk_en, bond_o, core_en, par_en, vld, to_enc, ferr;
  logic        bond_i = 1'b0;
  logic [39:0] fdata;
  logic [39:0] word = 40'hF5_A5AB_CDE3;
  logic [19:0] odata;
  logic [1:0]  fmode = 2'h1;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          pc, cc, bc, ec, vc;

  tpfs_top dut (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .FAB_DATA_I(fdata), .FAB_CLK_EN_I(fclk_en),
    .BOND_EN_I(bond_i), .BOND_EN_O(bond_o), .CORE_EN_O(core_en), .PAR_EN_O(par_en),
    .OUT_DATA_O(odata), .OUT_VALID_O(vld), .OUT_TO_ENC_O(to_enc), .FIFO_ERR_O(ferr));

  tpfs_fab_model fab (.clk_i(clk), .arst_n_i(rst_n), .mode_i(fmode), .word_i(word),
    .core_en_i(core_en), .fab_data_o(fdata), .fab_clk_en_o(fclk_en));

  always #5 clk = ~clk;

  // hang guard; whole run is well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // idle cycle after each transfer so strobes never change twice in a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic er);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp);
  endtask : rdc

  task cfg(input logic [31:0] v);
    wr(`TPFS_CTRL_OFS, v | 32'h1);
    wr(`TPFS_CTRL_OFS, v);
  endtask : cfg

  task cnt(input int n);
    pc = 0; cc = 0; bc = 0; ec = 0; vc = 0;
    repeat (n) begin
      @(posedge clk);
      pc += (par_en === 1'b1);
      cc += (core_en === 1'b1);
      bc += (bond_o === 1'b1);
      ec += (ferr === 1'b1);
      vc += (vld === 1'b1);
    end
  endtask : cnt

  task t_regs;
    logic [31:0] r;
    logic        e;
    rdc(`TPFS_CTRL_OFS, `TPFS_CTRL_RST, 32'hFFFF_FFFF);
    rdc(`TPFS_STAT_OFS, 32'h800, 32'h800);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(`TPFS_CTRL_OFS, 32'hFFFF_FFFF);
    rdc(`TPFS_CTRL_OFS, `TPFS_CTRL_MSK, 32'hFFFF_FFFF);
    wr(`TPFS_CTRL_OFS, 32'h1);
    cnt(30);
    chk(vc, 0);
  endtask : t_regs

  task t_div;
    for (int d = 0; d < 3; d++) begin
      cfg(d << `TPFS_C_DIV);
      cnt(40);
      chk(pc, 40 / (1 << d));
    end
  endtask : t_div

  task t_bond;
    cfg((1 << `TPFS_C_BOND) | (1 << `TPFS_C_BS));
    cnt(40);
    chk(cc * 2, pc);
    cfg(1 << `TPFS_C_BOND);
    cnt(40);
    chk(cc, pc);
    cfg(32'hE | (`TPFS_DIV2 << `TPFS_C_DIV));
    cnt(40);
    chk(bc, 20);
    cfg(32'h6);
    cnt(40);
    chk(pc, 0);
  endtask : t_bond

  // serializer on keeps the fabric side at half rate
  task t_bs(input logic enc, input logic w10);
    logic [19:0] m, lo, hi;
    int          k;
    m  = w10 ? 20'h3FF : 20'hFF;
    lo = word[19:0] & m;
    hi = (word[19:0] >> (w10 ? 10 : 8)) & m;
    cfg((1 << `TPFS_C_BS) | (enc << `TPFS_C_ENC) | (w10 << `TPFS_C_W10));
    k = 0;
    repeat (60) begin
      @(posedge clk);
      if (vld === 1'b1 && k < 4) begin
        chk(odata, k[0] ? hi : lo);
        k++;
      end
    end
    chk(k, 4);
    chk(to_enc, enc & ~w10);
    cnt(40);
    chk(vc, 40);
    chk(ec, 0);
  endtask : t_bs

  task t_route;
    logic [31:0] rv[4];
    rv = '{32'h200, 32'h600, 32'h300, 32'h0};
    for (int i = 0; i < 4; i++) begin
      cfg(rv[i]);
      repeat (8) @(posedge clk);
      chk(to_enc, i == 0);
    end
  endtask : t_route

  task t_mode;
    logic [31:0] m, d;
    for (int p = 0; p < 4; p++) begin
      cfg((p << `TPFS_C_PRO) | 32'hC0);
      m = (p == 1) ? 32'h1 : (p == 2) ? 32'h2 : 32'h0;
      d = (p == 0 || p == 2);
      rdc(`TPFS_STAT_OFS, (m << 6) | (d << 9) | (!d << 8), 32'h3C0);
    end
  endtask : t_mode

  task t_err;
    logic [31:0] v;
    v = (1 << `TPFS_C_FCLK) | (`TPFS_DIV4 << `TPFS_C_DIV);
    fmode <= 2'h2;
    cfg(v);
    cnt(40);
    chk(ec != 0, 1);
    rdc(`TPFS_STAT_OFS, 32'h1, 32'h1);
    fmode <= 2'h0;
    cfg(v);
    cnt(40);
    chk(ec != 0, 1);
    wr(`TPFS_CTRL_OFS, v | 32'h1);
    wr(`TPFS_STAT_OFS, 32'h1);
    rdc(`TPFS_STAT_OFS, 32'h0, 32'h1);
    fmode <= 2'h1;
    cfg(v);
    cnt(20);
    cnt(40);
    chk(vc, 10);
    chk(ec, 0);
  endtask : t_err

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_div();
    t_bond();
    for (int i = 0; i < 4; i++) t_bs(i[0], i[1]);
    t_route();
    t_mode();
    t_err();
    give_verdict();
  end
endmodule : tb
